// ===== verilog/mtl_pkg.sv
// constants for the memory type range lookup block
// assumes a 32-bit physical address space and an AXI4-Lite register bus
package mtl_pkg;
    // memory type encodings
    localparam logic [2:0] MT_UNCACHEABLE = 3'h0;
    localparam logic [2:0] MT_WRITE_COMB  = 3'h1;
    localparam logic [2:0] MT_WRITE_THRU  = 3'h4;
    localparam logic [2:0] MT_WRITE_PROT  = 3'h5;
    localparam logic [2:0] MT_WRITE_BACK  = 3'h6;
    // variable pair storage and reported count
    localparam int         NUM_PAIRS      = 8;
    localparam logic [7:0] PAIR_COUNT     = 8'h08;
    localparam logic       FIXED_SUPPORT  = 1'b1;
    // fixed granule counts: 8 x 64K, 16 x 16K, 64 x 4K
    localparam int         NUM_FIXED      = 88;
    localparam int         FIX16_BASE     = 8;
    localparam int         FIX4_BASE      = 24;
    // fixed region boundaries
    localparam logic [31:0] FIX64_END     = 32'h0007_FFFF;
    localparam logic [31:0] FIX16_END     = 32'h000B_FFFF;
    localparam logic [31:0] FIX4_END      = 32'h000F_FFFF;
    // register byte offsets
    localparam logic [11:0] OFS_CAP       = 12'h000;
    localparam logic [11:0] OFS_DEF       = 12'h004;
    localparam logic [11:0] OFS_BASE0     = 12'h100;
    localparam logic [11:0] OFS_MASK0     = 12'h104;
    localparam logic [11:0] OFS_FIX0      = 12'h200;
    // field positions
    localparam int          DEF_EN_BIT    = 11;
    localparam int          DEF_FIX_EN_BIT = 10;
    localparam int          CAP_FIX_BIT   = 8;
    localparam int          MASK_V_BIT    = 11;
    // reset values
    localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
    // response codes
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ===== verilog/mtl_lookup.sv
// range registers with AXI4-Lite access and a registered type lookup
// assumes software keeps the update discipline around range changes
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - enable clear forces every access uncacheable
// RULE_02 - fixed map: 64K, 16K, 4K granules
// RULE_03 - fixed type used when supported and enabled
// RULE_04 - scan as many pairs as count reports
// RULE_05 - invalid pair never matches
// RULE_06 - masked address equals masked base matches
// RULE_07 - no match falls back to default type
// RULE_08 - query software aligns, reports mixed result
// RULE_09 - assign software rejects misaligned, zero, wrapping
// RULE_10 - software checks pairs before programming
// RULE_11 - software disables interrupts, enters no-fill
// RULE_12 - software writes back, invalidates caches
// RULE_13 - software clears global pages, flushes translations
// RULE_14 - software disables ranges during update
// RULE_15 - software flushes again after re-enable
// RULE_16 - software restores cache mode, interrupts
// RULE_17 - multiprocessor software loads identical settings
// RULE_18 - software broadcasts and synchronizes updates
module mtl_lookup (
    // clock and reset
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST_N,
    // lookup request
    input  wire logic        I_LK_VALID,
    input  wire logic [31:0] I_LK_ADDR,
    // lookup answer
    output logic             O_LK_VALID,
    output logic [2:0]       O_LK_TYPE,
    // axi write address
    input  wire logic        I_AWVALID,
    input  wire logic [11:0] I_AWADDR,
    output logic             O_AWREADY,
    // axi write data
    input  wire logic        I_WVALID,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    output logic             O_WREADY,
    // axi write response
    output logic             O_BVALID,
    output logic [1:0]       O_BRESP,
    input  wire logic        I_BREADY,
    // axi read address
    input  wire logic        I_ARVALID,
    input  wire logic [11:0] I_ARADDR,
    output logic             O_ARREADY,
    // axi read data
    output logic             O_RVALID,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    input  wire logic        I_RREADY
);

    ////////////////////////////////////////////////////////////////////
    // storage
    logic [31:0] def_reg;                          // default type register
    logic [31:0] base_reg [mtl_pkg::NUM_PAIRS];    // range base registers
    logic [31:0] mask_reg [mtl_pkg::NUM_PAIRS];    // range mask registers
    logic [2:0]  fix_reg  [mtl_pkg::NUM_FIXED];    // one type per granule
    logic [11:0] awaddr_reg;                       // captured write address
    logic [31:0] wdata_reg;                        // captured write data
    logic [3:0]  wstrb_reg;                        // captured strobes
    logic        aw_have_reg;                      // address held
    logic        w_have_reg;                       // data held
    logic        do_write;                         // both halves present

    ////////////////////////////////////////////////////////////////////
    // write channels: take address and data in either order
    assign do_write = aw_have_reg && w_have_reg && !O_BVALID;

    // write address capture
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            aw_have_reg <= 1'b0;
            awaddr_reg  <= 12'h000;
            O_AWREADY   <= 1'b0;
        end else if (do_write) begin
            aw_have_reg <= 1'b0;                   // release after use
            O_AWREADY   <= 1'b0;
        end else if (I_AWVALID && O_AWREADY) begin
            aw_have_reg <= 1'b1;
            awaddr_reg  <= I_AWADDR;
            O_AWREADY   <= 1'b0;
        end else begin
            O_AWREADY   <= !aw_have_reg && !O_BVALID;
        end
    end

    // write data capture
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            w_have_reg <= 1'b0;
            wdata_reg  <= mtl_pkg::RST_ZERO;
            wstrb_reg  <= 4'h0;
            O_WREADY   <= 1'b0;
        end else if (do_write) begin
            w_have_reg <= 1'b0;
            O_WREADY   <= 1'b0;
        end else if (I_WVALID && O_WREADY) begin
            w_have_reg <= 1'b1;
            wdata_reg  <= I_WDATA;
            wstrb_reg  <= I_WSTRB;
            O_WREADY   <= 1'b0;
        end else begin
            O_WREADY   <= !w_have_reg && !O_BVALID;
        end
    end

    // decode helpers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // whether an address is word-aligned inside the pair window or the fixed window
    function automatic logic is_pair(input logic [11:0] a);
        return (a >= mtl_pkg::OFS_BASE0) &&
               (a < mtl_pkg::OFS_BASE0 + 12'(8 * mtl_pkg::NUM_PAIRS)) &&
               (a[1:0] == 2'h0);
    endfunction

    function automatic logic is_fix(input logic [11:0] a);
        return (a >= mtl_pkg::OFS_FIX0) &&
               (a < mtl_pkg::OFS_FIX0 + 12'(4 * mtl_pkg::NUM_FIXED)) &&
               (a[1:0] == 2'h0);
    endfunction

    logic        wr_ok;                            // write hits a register
    logic [11:0] wr_pofs;                          // offset in pair window
    logic [11:0] wr_fofs;                          // offset in fixed window
    assign wr_pofs = awaddr_reg - mtl_pkg::OFS_BASE0;
    assign wr_fofs = awaddr_reg - mtl_pkg::OFS_FIX0;
    assign wr_ok   = (awaddr_reg == mtl_pkg::OFS_DEF) ||
                     is_pair(awaddr_reg) || is_fix(awaddr_reg);

    // default type register; reset clears enables
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            def_reg <= mtl_pkg::RST_ZERO;
        end else if (do_write && awaddr_reg == mtl_pkg::OFS_DEF) begin
            def_reg <= merge(def_reg, wdata_reg, wstrb_reg) & 32'h0000_0C07;
        end
    end

    // pair registers, one slot per generate entry
    genvar gp;
    generate
        for (gp = 0; gp < mtl_pkg::NUM_PAIRS; gp++) begin : g_pair
            always_ff @(posedge I_CLK_SYS) begin
                if (!I_RST_N) begin
                    base_reg[gp] <= mtl_pkg::RST_ZERO;
                    mask_reg[gp] <= mtl_pkg::RST_ZERO; // valid bit clear
                end else if (do_write && is_pair(awaddr_reg) &&
                             wr_pofs[11:3] == 9'(gp)) begin
                    if (wr_pofs[2]) begin
                        mask_reg[gp] <= merge(mask_reg[gp], wdata_reg,
                                              wstrb_reg) & 32'hFFFF_F800;
                    end else begin
                        base_reg[gp] <= merge(base_reg[gp], wdata_reg,
                                              wstrb_reg) & 32'hFFFF_F007;
                    end
                end
            end
        end
    endgenerate

    // fixed granule types
    genvar gf;
    generate
        for (gf = 0; gf < mtl_pkg::NUM_FIXED; gf++) begin : g_fix
            always_ff @(posedge I_CLK_SYS) begin
                if (!I_RST_N) begin
                    fix_reg[gf] <= mtl_pkg::MT_UNCACHEABLE;
                end else if (do_write && is_fix(awaddr_reg) &&
                             wr_fofs[11:2] == 10'(gf) && wstrb_reg[0]) begin
                    fix_reg[gf] <= wdata_reg[2:0];
                end
            end
        end
    endgenerate

    // write response; unmapped writes answer slverr
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            O_BVALID <= 1'b0;
            O_BRESP  <= mtl_pkg::RESP_OKAY;
        end else if (do_write) begin
            O_BVALID <= 1'b1;
            O_BRESP  <= wr_ok ? mtl_pkg::RESP_OKAY : mtl_pkg::RESP_SLVERR;
        end else if (O_BVALID && I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read channel: one read at a time, answer one cycle after address
    logic [31:0] rd_val;                           // decoded read word
    logic        rd_ok;                            // read hits a register
    logic [11:0] rd_pofs;
    logic [11:0] rd_fofs;
    assign rd_pofs = I_ARADDR - mtl_pkg::OFS_BASE0;
    assign rd_fofs = I_ARADDR - mtl_pkg::OFS_FIX0;

    // read mux
    always_comb begin
        rd_val = mtl_pkg::RST_ZERO;
        rd_ok  = 1'b1;
        if (I_ARADDR == mtl_pkg::OFS_CAP) begin
            rd_val[7:0]                  = mtl_pkg::PAIR_COUNT;
            rd_val[mtl_pkg::CAP_FIX_BIT] = mtl_pkg::FIXED_SUPPORT;
        end else if (I_ARADDR == mtl_pkg::OFS_DEF) begin
            rd_val = def_reg;
        end else if (is_pair(I_ARADDR)) begin
            rd_val = rd_pofs[2] ? mask_reg[rd_pofs[5:3]]
                                : base_reg[rd_pofs[5:3]];
        end else if (is_fix(I_ARADDR)) begin
            rd_val[2:0] = fix_reg[rd_fofs[8:2]];
        end else begin
            rd_ok = 1'b0;                          // unmapped
        end
    end

    // read handshake
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= mtl_pkg::RST_ZERO;
            O_RRESP   <= mtl_pkg::RESP_OKAY;
        end else if (I_ARVALID && O_ARREADY) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b1;
            O_RDATA   <= rd_val;
            O_RRESP   <= rd_ok ? mtl_pkg::RESP_OKAY : mtl_pkg::RESP_SLVERR;
        end else if (O_RVALID && I_RREADY) begin
            O_RVALID  <= 1'b0;
        end else begin
            O_ARREADY <= !O_RVALID;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // lookup, one cycle from request to answer
    logic [2:0]  lk_type;                          // resolved type
    logic [6:0]  fix_idx;                          // granule index
    logic        in_fixed;                         // below 1 MByte
    logic        var_hit;
    logic [2:0]  var_type;

    // fixed granule selection
    always_comb begin
        in_fixed = (I_LK_ADDR <= mtl_pkg::FIX4_END);
        fix_idx  = 7'h00;
        // RULE_02 granule split
        if (I_LK_ADDR <= mtl_pkg::FIX64_END) begin
            fix_idx = 7'(I_LK_ADDR[18:16]);
        end else if (I_LK_ADDR <= mtl_pkg::FIX16_END) begin
            fix_idx = 7'(mtl_pkg::FIX16_BASE) + 7'(I_LK_ADDR[17:14]);
        end else begin
            fix_idx = 7'(mtl_pkg::FIX4_BASE) + 7'(I_LK_ADDR[17:12]);
        end
    end

    // variable pair scan; lowest matching pair wins, overlap is
    // left to software as undefined territory
    always_comb begin
        var_hit  = 1'b0;
        var_type = mtl_pkg::MT_UNCACHEABLE;
        for (int p = mtl_pkg::NUM_PAIRS - 1; p >= 0; p--) begin
            // RULE_04 RULE_05 RULE_06 count, valid, masked compare
            if (8'(p) < mtl_pkg::PAIR_COUNT &&
                mask_reg[p][mtl_pkg::MASK_V_BIT] &&
                ((I_LK_ADDR & {mask_reg[p][31:12], 12'h000}) ==
                 (base_reg[p] & {mask_reg[p][31:12], 12'h000}))) begin
                var_hit  = 1'b1;
                var_type = base_reg[p][2:0];
            end
        end
    end

    // precedence: disable, fixed, variable, default
    always_comb begin
        // RULE_01 disabled means uncacheable
        if (!def_reg[mtl_pkg::DEF_EN_BIT]) begin
            lk_type = mtl_pkg::MT_UNCACHEABLE;
        // RULE_03 fixed region takes priority
        end else if (mtl_pkg::FIXED_SUPPORT &&
                     def_reg[mtl_pkg::DEF_FIX_EN_BIT] && in_fixed) begin
            lk_type = fix_reg[fix_idx];
        end else if (var_hit) begin
            lk_type = var_type;
        // RULE_07 default fallback
        end else begin
            lk_type = def_reg[2:0];
        end
    end

    // registered answer
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            O_LK_VALID <= 1'b0;
            O_LK_TYPE  <= mtl_pkg::MT_UNCACHEABLE;
        end else begin
            O_LK_VALID <= I_LK_VALID;
            O_LK_TYPE  <= lk_type;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    localparam int DEF_EN     = mtl_pkg::DEF_EN_BIT;      // global enable
    localparam int DEF_FIX_EN = mtl_pkg::DEF_FIX_EN_BIT;  // fixed enable
    a_disable_forces_uc: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_RST_N)
        (I_LK_VALID && !def_reg[mtl_pkg::DEF_EN_BIT]) |=>
        (O_LK_TYPE == mtl_pkg::MT_UNCACHEABLE))  // RULE_01
        else $error("disabled ranges gave a cached type");
    a_fixed_lookup: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_RST_N)
        (I_LK_VALID && def_reg[DEF_EN] && def_reg[DEF_FIX_EN] &&
         I_LK_ADDR <= mtl_pkg::FIX64_END) |=>
        (O_LK_TYPE == fix_reg[$past(I_LK_ADDR[18:16])]))  // RULE_03
        else $error("fixed granule type not used");
    a_fixed_small: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_RST_N)
        (I_LK_VALID && def_reg[DEF_EN] && def_reg[DEF_FIX_EN] &&
         I_LK_ADDR > mtl_pkg::FIX16_END &&
         I_LK_ADDR <= mtl_pkg::FIX4_END) |=>
        (O_LK_TYPE == fix_reg[7'(mtl_pkg::FIX4_BASE) +
                              7'($past(I_LK_ADDR[17:12]))]))  // RULE_02
        else $error("4K granule index wrong");
    a_default_fallback: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_RST_N)
        (I_LK_VALID && def_reg[DEF_EN] && !var_hit &&
         !(def_reg[DEF_FIX_EN] && in_fixed)) |=>
        (O_LK_TYPE == $past(def_reg[2:0])))  // RULE_07
        else $error("default type not used");
    a_invalid_pair: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_RST_N)
        (mask_reg[0][mtl_pkg::MASK_V_BIT] == 1'b0 &&
         mask_reg[1][mtl_pkg::MASK_V_BIT] == 1'b0 &&
         mask_reg[2][mtl_pkg::MASK_V_BIT] == 1'b0 &&
         mask_reg[3][mtl_pkg::MASK_V_BIT] == 1'b0 &&
         mask_reg[4][mtl_pkg::MASK_V_BIT] == 1'b0 &&
         mask_reg[5][mtl_pkg::MASK_V_BIT] == 1'b0 &&
         mask_reg[6][mtl_pkg::MASK_V_BIT] == 1'b0 &&
         mask_reg[7][mtl_pkg::MASK_V_BIT] == 1'b0) |-> !var_hit)  // RULE_05
        else $error("invalid pair matched");
    a_pair0_match: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_RST_N)
        (I_LK_VALID && def_reg[DEF_EN] && !in_fixed &&
         mask_reg[0][mtl_pkg::MASK_V_BIT] &&
         ((I_LK_ADDR ^ base_reg[0]) & {mask_reg[0][31:12], 12'h000})
            == 32'h0) |=>
        (O_LK_TYPE == $past(base_reg[0][2:0])))  // RULE_06 RULE_04
        else $error("pair zero match lost");
    a_read_answer: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_RST_N)
        (I_ARVALID && O_ARREADY) |=> O_RVALID)
        else $error("read not answered in one cycle");
    a_write_answer: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_RST_N)
        do_write |=> (O_BVALID && !aw_have_reg && !w_have_reg))
        else $error("write not answered");

endmodule

// ===== testbench/mtl_lookup_test.sv
// self-checking bench for the memory type range lookup block
// assumes the block is alone on its register bus and lookup port
`timescale 1ns/1ps

module mtl_lookup_test;
    ////////////////////////////////////////////////////////////////////
    // signals at the block's ports
    logic        clk;          // 40 MHz system clock
    logic        rst_n;        // synchronous reset, active low
    logic        lk_valid;     // lookup request strobe
    logic [31:0] lk_addr;      // lookup address
    logic        lk_done;      // lookup answer strobe
    logic [2:0]  lk_type;      // resolved type
    logic        awvalid;      // write address channel
    logic [11:0] awaddr;
    logic        awready;
    logic        wvalid;       // write data channel
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wready;
    logic        bvalid;       // write response channel
    logic [1:0]  bresp;
    logic        bready;
    logic        arvalid;      // read address channel
    logic [11:0] araddr;
    logic        arready;
    logic        rvalid;       // read data channel
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rready;
    int          n_errors;     // mismatches seen
    int          total_checks; // comparisons made
    logic [31:0] lk_a[$];      // addresses of one lookup burst
    logic [2:0]  lk_e[$];      // expected types of that burst

    ////////////////////////////////////////////////////////////////////
    // device under test
    mtl_lookup DUT (
        .I_CLK_SYS (clk),     .I_RST_N   (rst_n),
        .I_LK_VALID(lk_valid), .I_LK_ADDR (lk_addr),
        .O_LK_VALID(lk_done), .O_LK_TYPE (lk_type),
        .I_AWVALID (awvalid), .I_AWADDR  (awaddr), .O_AWREADY(awready),
        .I_WVALID  (wvalid),  .I_WDATA   (wdata),  .I_WSTRB  (wstrb),
        .O_WREADY  (wready),  .O_BVALID  (bvalid), .O_BRESP  (bresp),
        .I_BREADY  (bready),  .I_ARVALID (arvalid), .I_ARADDR (araddr),
        .O_ARREADY (arready), .O_RVALID  (rvalid), .O_RDATA  (rdata),
        .O_RRESP   (rresp),   .I_RREADY  (rready)
    );

    // free-running clock, 25 ns period
    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    // comparison and verdict
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // register bus master; readies are sampled at the edge itself,
    // before the block's own updates land
    task automatic bus_write(input logic [11:0] a, input logic [31:0] d,
                             input logic [1:0] er);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        bready  <= 1'b1;
        while (!done && n < 200) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                done = 1'b1;
                check("write response", {30'h0, bresp}, {30'h0, er});
            end
        end
        check("write completes", {31'h0, done}, 32'h1);
    endtask

    task automatic bus_read(input logic [11:0] a, input logic [31:0] ed,
                            input logic [1:0] er);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        while (!done && n < 200) begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0;
                done = 1'b1;
                check("read data", rdata, ed);
                check("read response", {30'h0, rresp}, {30'h0, er});
            end
        end
        check("read completes", {31'h0, done}, 32'h1);
    endtask

    // one variable pair: base then mask
    task automatic set_pair(input int n, input logic [31:0] b,
                            input logic [31:0] m);
        bus_write(mtl_pkg::OFS_BASE0 + 12'(8 * n), b, mtl_pkg::RESP_OKAY);
        bus_write(mtl_pkg::OFS_MASK0 + 12'(8 * n), m, mtl_pkg::RESP_OKAY);
    endtask

    // one fixed granule type
    task automatic set_fixed(input int k, input logic [2:0] t);
        bus_write(mtl_pkg::OFS_FIX0 + 12'(4 * k), {29'h0, t},
                  mtl_pkg::RESP_OKAY);
    endtask

    // back-to-back lookups, one request every cycle
    task automatic run_lookups();
        for (int i = 0; i <= lk_a.size(); i++) begin
            @(posedge clk);
            lk_valid <= (i < lk_a.size());
            if (i < lk_a.size()) lk_addr <= lk_a[i];
            #1;
            if (i > 0) begin
                check("lookup strobe", {31'h0, lk_done}, 32'h1);
                check("lookup type", {29'h0, lk_type}, {29'h0, lk_e[i-1]});
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        lk_valid = 1'b1;
        lk_addr = 32'h0000_0000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        n_errors = 0;
        total_checks = 0;
        // requests during reset must not be answered
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        lk_valid <= 1'b0;
        #1;
        check("reset strobe", {31'h0, lk_done}, 32'h0);
        check("reset type", {29'h0, lk_type}, 32'h0);
        bus_read(mtl_pkg::OFS_CAP, {23'h0, mtl_pkg::FIXED_SUPPORT,
                 mtl_pkg::PAIR_COUNT}, mtl_pkg::RESP_OKAY);
        bus_read(mtl_pkg::OFS_DEF, 32'h0, mtl_pkg::RESP_OKAY);
        // unmapped and misaligned places are refused
        bus_read(12'h080, 32'h0, mtl_pkg::RESP_SLVERR);
        bus_read(12'h102, 32'h0, mtl_pkg::RESP_SLVERR);
        bus_write(12'h360, 32'hFFFF_FFFF, mtl_pkg::RESP_SLVERR);
        // pairs 0, 1, 7 valid; pair 2 left invalid on purpose
        // aligned power-of-two ranges only
        set_pair(0, 32'h0000_0006, 32'hFC00_0800);
        set_pair(1, 32'hA000_0001, 32'hFF80_0800);
        set_pair(2, 32'h0800_0004, 32'hFF00_0000);
        set_pair(7, 32'h1000_0004, 32'hFFFF_F800);
        set_fixed(7, mtl_pkg::MT_WRITE_THRU);
        set_fixed(8, mtl_pkg::MT_WRITE_COMB);
        set_fixed(23, mtl_pkg::MT_WRITE_PROT);
        set_fixed(24, mtl_pkg::MT_WRITE_COMB);
        set_fixed(87, mtl_pkg::MT_WRITE_THRU);
        // fixed on, global off: all uncacheable
        bus_write(mtl_pkg::OFS_DEF, 32'h0000_0405, mtl_pkg::RESP_OKAY);
        lk_a = '{32'h0000_1000, 32'hA000_0000, 32'h0007_0000, 32'h2000_0000};
        lk_e = '{3'h0, 3'h0, 3'h0, 3'h0};
        run_lookups();
        // global on, fixed off; junk in the other bits must read 0
        bus_write(mtl_pkg::OFS_DEF, 32'hFFFF_F8FD, mtl_pkg::RESP_OKAY);
        bus_read(mtl_pkg::OFS_DEF, 32'h0000_0805, mtl_pkg::RESP_OKAY);
        bus_read(mtl_pkg::OFS_MASK0, 32'hFC00_0800, mtl_pkg::RESP_OKAY);
        bus_read(12'h114, 32'hFF00_0000, mtl_pkg::RESP_OKAY);
        bus_read(12'h35C, 32'h0000_0004, mtl_pkg::RESP_OKAY);
        lk_a = '{32'h0000_1000, 32'h03FF_FFFF, 32'h0400_0000, 32'hA000_0000,
                 32'hA07F_FFFF, 32'hA080_0000, 32'h0800_0010, 32'h1000_0FFF,
                 32'h1000_1000, 32'h0007_0000};
        lk_e = '{3'h6, 3'h6, 3'h5, 3'h1, 3'h1, 3'h5, 3'h5, 3'h4, 3'h5, 3'h6};
        // neighbouring 4K pages at the edge of pair 7 resolve to different types
        run_lookups();
        // fixed granules win below 1 MByte
        bus_write(mtl_pkg::OFS_DEF, 32'h0000_0C05, mtl_pkg::RESP_OKAY);
        lk_a = '{32'h0006_FFFF, 32'h0007_0000, 32'h0007_FFFF, 32'h0008_0000,
                 32'h0008_3FFF, 32'h0008_4000, 32'h000B_FFFF, 32'h000C_0000,
                 32'h000C_1000, 32'h000F_F000, 32'h0010_0000};
        lk_e = '{3'h0, 3'h4, 3'h4, 3'h1, 3'h1, 3'h0, 3'h5, 3'h1, 3'h0, 3'h4,
                 3'h6};
        run_lookups();
        // global off overrides enabled fixed ranges too
        // no cache, tlb or irq port here
        bus_write(mtl_pkg::OFS_DEF, 32'h0000_0405, mtl_pkg::RESP_OKAY);
        lk_a = '{32'h0007_0000, 32'h1000_0000};
        lk_e = '{3'h0, 3'h0};
        run_lookups();
        // byte lanes: only lane 1 lands, the low byte keeps its type
        wstrb <= 4'h2;
        bus_write(mtl_pkg::OFS_DEF, 32'h0000_08FF,
                  mtl_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        bus_read(mtl_pkg::OFS_DEF, 32'h0000_0805,
                 mtl_pkg::RESP_OKAY);
        // global on, fixed off: pair match, then default
        lk_a = '{32'h0007_0000, 32'h2000_0000};
        lk_e = '{3'h6, 3'h5};
        run_lookups();
        end_of_test();
    end
endmodule
